// [rtl/bnvp_consts.vh]
// Timing constants for the bytewide nonvolatile RAM host controller.
// Assumes a 10 MHz system clock; counts are derived from ns figures.
`ifndef BNVP_CONSTS_VH
`define BNVP_CONSTS_VH

// Clock period in ns
`define BNVP_CLK_NS          100
// Chip select low time, read access and write select-to-strobe (ns)
`define BNVP_T_CA_NS         70
`define BNVP_T_CE_NS         70
`define BNVP_T_CW_NS         70
// Write strobe pulse width (ns)
`define BNVP_T_WP_NS         40
// Pre-charge and cycle time (ns)
`define BNVP_T_PC_NS         60
`define BNVP_T_RC_NS         130
// Output gate access and release times (ns)
`define BNVP_T_OE_NS         12
`define BNVP_T_HZ_NS         15
// Strobe high to device driving again (ns), least
`define BNVP_T_WX_NS         10
// Power-up wait in ms and ns per ms
`define BNVP_T_PU_MS         10
`define BNVP_NS_PER_MS       1000000

// Least times round up to whole cycles, at least one
`define BNVP_CYC_UP(ns) ((((ns) + `BNVP_CLK_NS - 1) / `BNVP_CLK_NS) < 1 ? 1 : \
  (((ns) + `BNVP_CLK_NS - 1) / `BNVP_CLK_NS))
// Longest times round down, at least one
`define BNVP_CYC_DN(ns) (((ns) / `BNVP_CLK_NS) < 1 ? 1 : ((ns) / `BNVP_CLK_NS))

`define BNVP_CA_CYC  `BNVP_CYC_UP(`BNVP_T_CA_NS)
`define BNVP_CW_CYC  `BNVP_CYC_UP(`BNVP_T_CW_NS)
`define BNVP_WP_CYC  `BNVP_CYC_UP(`BNVP_T_WP_NS)
`define BNVP_PC_CYC  `BNVP_CYC_UP(`BNVP_T_PC_NS)
`define BNVP_RC_CYC  `BNVP_CYC_UP(`BNVP_T_RC_NS)
// Cycles from select fall until read data are valid (access plus gate)
`define BNVP_ACC_CYC `BNVP_CYC_UP(`BNVP_T_CE_NS + `BNVP_T_OE_NS)
// Bus turnaround after the device releases its data lines
`define BNVP_HZ_CYC  `BNVP_CYC_UP(`BNVP_T_HZ_NS)
// Power-up wait in cycles
`define BNVP_PU_CYC  ((`BNVP_T_PU_MS * `BNVP_NS_PER_MS) / `BNVP_CLK_NS)

`endif

// [rtl/bnvp_sync.v]
// Two-flop synchroniser bank for the data pins read back from the RAM.
// Assumes the pins are asynchronous to clock; output is the second flop.
`timescale 1ns/1ps
module bnvp_sync #(
  parameter WIDTH = 8
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_q;   // First stage, read only by the second
  reg [WIDTH-1:0] stable_q; // Second stage, safe for logic

  // Both stages clear on reset to constants
  always @(posedge clock) begin
    if (!rst_n) begin
      meta_q   <= {WIDTH{1'b0}};
      stable_q <= {WIDTH{1'b0}};
    end else begin
      meta_q   <= asyncIn;
      stable_q <= meta_q;
    end
  end

  assign syncOut = stable_q;
endmodule // bnvp_sync

// [rtl/bnvp_host.v]
// Host controller for a 32K x 8 bytewide nonvolatile RAM port.
// Assumes a 10 MHz clock, request/answer handshake from local logic,
// and a board wire that resolves the data pins from both enables.
// Read data arrive two cycles late, the price of synchronising pins.
`timescale 1ns/1ps
`include "bnvp_consts.vh"

// Operation
// - Hold select low at least 70 ns
// - Select low 70 ns before strobe rises
// - Write strobe low at least 40 ns
// - Wait 10 ms after power before access
module bnvp_host #(
  parameter ADDR_W = 15,
  parameter DATA_W = 8,
  parameter PU_CYC = `BNVP_PU_CYC
) (
  input  wire              clock,
  input  wire              rst_n,
  // Local request side
  input  wire              reqValid,
  input  wire              reqWrite,
  input  wire [ADDR_W-1:0] reqAddr,
  input  wire [DATA_W-1:0] reqData,
  output reg               reqReady,
  output reg               rspValid,
  output reg  [DATA_W-1:0] rspData,
  // RAM pins
  output reg               memSelN,
  output reg               memStrobeN,
  output reg               memGateN,
  output reg  [ADDR_W-1:0] memAddr,
  output reg  [DATA_W-1:0] memDataOut,
  output reg               memDataOe,
  input  wire [DATA_W-1:0] memDataIn
);
  // One-hot states
  localparam [5:0] ST_PWRUP = 6'h01; // Power-up wait
  localparam [5:0] ST_IDLE  = 6'h02; // Standby, ready for a request
  localparam [5:0] ST_RSEL  = 6'h04; // Read with select low
  localparam [5:0] ST_WSEL  = 6'h08; // Write with select and strobe low
  localparam [5:0] ST_WEND  = 6'h10; // Strobe high, select still low
  localparam [5:0] ST_PCHG  = 6'h20; // Pre-charge with select high

  // Phase lengths in cycles; kept at the 32 bits of the macros so that
  // no count is cut, and the counters are widened in phaseDone
  // Select low, least, in any access
  localparam [31:0] CA_CYC  = `BNVP_CA_CYC;
  // Select low before the strobe may rise
  localparam [31:0] CW_CYC  = `BNVP_CW_CYC;
  // Strobe low, least
  localparam [31:0] WP_CYC  = `BNVP_WP_CYC;
  // Select high between accesses, least
  localparam [31:0] PC_CYC  = `BNVP_PC_CYC;
  // Select fall to select fall, least
  localparam [31:0] RC_CYC  = `BNVP_RC_CYC;
  // Device release time before the next access may start
  localparam [31:0] HZ_CYC  = `BNVP_HZ_CYC;
  // Data pins lag two flops, so wait that much longer before sampling
  localparam [31:0] RD_CYC  = `BNVP_ACC_CYC + 32'h00000002;
  // Supply wait; a zero here is taken as one cycle, so the first request waits as it would for a one
  localparam [31:0] PU_LEN  = PU_CYC;

  reg  [5:0]        state_q;   // Current state
  reg  [23:0]       cnt_q;     // Phase counter
  reg  [23:0]       cyc_q;     // Cycles since select fell
  wire [DATA_W-1:0] dataSync;  // Read data after two flops

  bnvp_sync #(
    .WIDTH   (DATA_W)
  ) uSync (
    .clock   (clock),
    .rst_n   (rst_n),
    .asyncIn (memDataIn),
    .syncOut (dataSync)
  );

  // Saturating increment, shared by both counters
  function [23:0] incSat;
    input [23:0] v;
    begin
      incSat = (v == 24'hffffff) ? v : v + 24'h000001;
    end
  endfunction

  // True once a phase counter has covered lim cycles. The count is zero
  // on the first cycle of a phase, so the last one is lim-1; a zero
  // limit is treated as one cycle so that no phase can stall
  function phaseDone;
    input [23:0] cnt;
    input [31:0] lim;
    begin
      if (lim == 32'h00000000) begin
        phaseDone = 1'b1;
      end else begin
        phaseDone = ({8'h00, cnt} >= lim - 32'h00000001);
      end
    end
  endfunction

  // Main sequencer; every pin comes straight from a flop
  // Counters run free and saturate; each phase clears cnt_q as it opens
  always @(posedge clock) begin
    if (!rst_n) begin
      // Select, strobe and gate high keep the RAM in standby, and the
      // host floats its data pins until it owns a write
      state_q    <= ST_PWRUP;
      cnt_q      <= 24'h000000;
      cyc_q      <= 24'h000000;
      reqReady   <= 1'b0;
      rspValid   <= 1'b0;
      rspData    <= {DATA_W{1'b0}};
      memSelN    <= 1'b1;
      memStrobeN <= 1'b1;
      memGateN   <= 1'b1;
      memAddr    <= {ADDR_W{1'b0}};
      memDataOut <= {DATA_W{1'b0}};
      memDataOe  <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      cnt_q    <= incSat(cnt_q);
      cyc_q    <= incSat(cyc_q);
      case (state_q)
        // Hold off every access until the supply wait expires
        ST_PWRUP: begin
          // The count starts as reset lets go; the host cannot see the
          // supply itself, so reset must stay low until it is in range
          if (phaseDone(cnt_q, PU_LEN)) begin
            state_q  <= ST_IDLE;
            reqReady <= 1'b1;
          end
        end
        // Standby; a request lowers select and sets the address on the same edge
        ST_IDLE: begin
          if (reqValid) begin
            reqReady <= 1'b0;
            // Address and select change on one edge; the RAM latches the
            // address as select falls, with no setup time to wait out
            memAddr  <= reqAddr;
            memSelN  <= 1'b0;
            cnt_q    <= 24'h000000;
            cyc_q    <= 24'h000000;
            if (reqWrite) begin
              // Strobe falls with select: device starts the write and
              // floats its pins, so driving now cannot collide
              memStrobeN <= 1'b0;
              memDataOut <= reqData;
              memDataOe  <= 1'b1;
              state_q    <= ST_WSEL;
            end else begin
              // Strobe stays high, so this is a read; gate opens
              memGateN <= 1'b0;
              state_q  <= ST_RSEL;
            end
          end
        end
        // Read: sample once access and gate times plus sync delay pass
        ST_RSEL: begin
          // Both the access wait and the least select time must pass;
          // the first is at least two cycles longer at any clock, so it binds
          if (phaseDone(cnt_q, RD_CYC) &&
              phaseDone(cnt_q, CA_CYC)) begin
            rspData  <= dataSync;
            rspValid <= 1'b1;
            memSelN  <= 1'b1;
            memGateN <= 1'b1;
            cnt_q    <= 24'h000000;
            state_q  <= ST_PCHG;
          end
        end
        // Write: strobe low its pulse width and select low long enough
        ST_WSEL: begin
          // Strobe and select fall together, so the strobe width and the
          // select-to-strobe-rise time run from the same edge
          if (phaseDone(cnt_q, WP_CYC) &&
              phaseDone(cnt_q, CW_CYC) &&
              phaseDone(cnt_q, CA_CYC)) begin
            memStrobeN <= 1'b1;
            cnt_q      <= 24'h000000;
            state_q    <= ST_WEND;
          end
        end
        // Strobe high, data held one more cycle, then select rises
        // Holding data past the strobe rise gives the data hold time
        ST_WEND: begin
          memSelN   <= 1'b1;
          memDataOe <= 1'b0;
          cnt_q     <= 24'h000000;
          state_q   <= ST_PCHG;
        end
        // Pre-charge; the gate never steers the cycle itself
        ST_PCHG: begin
          // The cycle time never binds: select low plus pre-charge
          // cover it at this clock or any other, as 70 plus 60 ns make 130 ns
          if (phaseDone(cnt_q, PC_CYC) &&
              phaseDone(cnt_q, HZ_CYC) &&
              phaseDone(cyc_q, RC_CYC)) begin
            reqReady <= 1'b1;
            state_q  <= ST_IDLE;
          end
        end
        // Unknown code: park the pins in standby and start over
        default: begin
          state_q    <= ST_IDLE;
          memSelN    <= 1'b1;
          memStrobeN <= 1'b1;
          memGateN   <= 1'b1;
          memDataOe  <= 1'b0;
          reqReady   <= 1'b1;
        end
      endcase
    end
  end
endmodule // bnvp_host

// [tb/bnvp_ram_model.sv]
// Pin-level model of the bytewide RAM, the host's far side.
// Assumes host data and enable are fed in; the bus is resolved here.
`timescale 1ns/1ps
module bnvp_ram_model #(
  parameter ACC_NS = 70
) (
  input  wire        selN,
  input  wire        strobeN,
  input  wire        gateN,
  input  wire [14:0] addr,
  input  wire [7:0]  hostData,
  input  wire        hostOe,
  output wire [7:0]  bus
);
  reg  [7:0]  mem [0:32767]; // Storage array
  reg  [14:0] latAddr;       // Address caught as select falls
  reg         accDone;       // Access time has run out
  wire        drv;           // Device drives the data pins
  // Address latch and access timer both start on select fall
  always @(negedge selN) begin
    latAddr = addr;
    accDone <= #ACC_NS 1'b1;
  end
  always @(posedge selN) accDone <= 1'b0;
  // A write ends on whichever of strobe or select rises first
  always @(posedge strobeN) if (!selN) mem[latAddr] = hostData;
  always @(posedge selN) if (!strobeN) mem[latAddr] = hostData;
  // Output gate only touches the drivers; write strobe silences them
  assign drv = !selN &&
               !gateN &&
               strobeN &&
               accDone;
  // Released pins show the inverse, never a stale copy
  assign bus = hostOe ? hostData : (drv ? mem[latAddr] : ~mem[latAddr]);
endmodule // bnvp_ram_model

// [tb/bnvp_host_sva.sv]
// Pin timing checks for the RAM host controller.
// Assumes it is bound into bnvp_host; counts are clock cycles.
`timescale 1ns/1ps
module bnvp_host_sva #(
  parameter PU_CYC = 4
) (
  input wire clock,
  input wire rst_n,
  input wire reqValid,
  input wire reqWrite,
  input wire reqReady,
  input wire rspValid,
  input wire memSelN,
  input wire memStrobeN,
  input wire memGateN,
  input wire memDataOe
);
  reg [31:0] puCnt_q; // Cycles since reset release, saturating
  // Count the power-up wait the host must keep; wide enough for 10 ms
  always @(posedge clock)
    if (!rst_n) puCnt_q <= 32'h0;
    else if (puCnt_q < PU_CYC) puCnt_q <= puCnt_q + 32'h1;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_pu_wait: assert property (
    puCnt_q < PU_CYC |-> memSelN && !reqReady)
    else $error("access during power-up wait");
  chk_rd_sel_len: assert property (
    $fell(memSelN) && memStrobeN |-> !memSelN[*3] ##1 memSelN)
    else $error("read select width wrong");
  chk_wr_sel_len: assert property (
    $fell(memSelN) && !memStrobeN |-> !memSelN[*2] ##1 memSelN)
    else $error("write select width wrong");
  chk_strobe_width: assert property (
    $fell(memStrobeN) |-> !memStrobeN ##1 memStrobeN)
    else $error("strobe width wrong");
  chk_sel_before_rise: assert property (
    $rose(memStrobeN) |-> !memSelN && !$past(memSelN))
    else $error("strobe rose too soon after select");
  chk_pre_charge: assert property (
    $rose(memSelN) |-> memSelN[*2])
    else $error("pre-charge too short");
  chk_read_answer: assert property (
    reqValid && reqReady && !reqWrite |->
      ##1 !memSelN ##3 rspValid && memSelN)
    else $error("read answer timing wrong");
  chk_gate_read: assert property (
    !memGateN |-> !memSelN && memStrobeN && !memDataOe)
    else $error("gate open outside a read");
  chk_write_drive: assert property (
    !memStrobeN |-> memDataOe && !memSelN)
    else $error("strobe low without select and data");
  cov_read: cover property (rspValid);
  cov_write: cover property ($fell(memStrobeN));
  cov_busy_req: cover property (reqValid && !reqReady && puCnt_q == PU_CYC);
endmodule // bnvp_host_sva
bind bnvp_host bnvp_host_sva #(.PU_CYC(PU_CYC)) chkU (.clock(clock),
  .rst_n(rst_n), .reqValid(reqValid), .reqWrite(reqWrite),
  .reqReady(reqReady), .rspValid(rspValid), .memSelN(memSelN),
  .memStrobeN(memStrobeN), .memGateN(memGateN), .memDataOe(memDataOe));

// [tb/bytewide_nv_ram_port_tb.sv]
// Self-checking bench: host controller against the RAM model.
// Assumes a shortened power-up wait and a 10 MHz clock.
`timescale 1ns/1ps
module bytewide_nv_ram_port_tb;
  localparam PU = 4; // Short power-up wait keeps the run brief
  reg         clock = 1'b0;
  reg         rst_n = 1'b0;
  reg         reqValid = 1'b0;
  reg         reqWrite = 1'b0;
  reg  [14:0] reqAddr = 15'h0;
  reg  [7:0]  reqData = 8'h0;
  wire        reqReady, rspValid, memSelN, memStrobeN, memGateN, memDataOe;
  wire [7:0]  rspData, memDataOut, busIn;
  wire [14:0] memAddr;
  integer     err_total = 0, n_tests = 0, cyc = 0;
  always #50 clock = ~clock;
  bnvp_host #(.PU_CYC(PU)) dut_u (.clock(clock), .rst_n(rst_n),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .memSelN(memSelN), .memStrobeN(memStrobeN),
    .memGateN(memGateN), .memAddr(memAddr), .memDataOut(memDataOut),
    .memDataOe(memDataOe), .memDataIn(busIn));
  bnvp_ram_model ram_u (.selN(memSelN), .strobeN(memStrobeN),
    .gateN(memGateN), .addr(memAddr), .hostData(memDataOut),
    .hostOe(memDataOe), .bus(busIn));
  task check(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask
  task close_out;
    $display("Checks %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Offer one request and hold it until the edge that takes it
  task req(input logic w, input logic [14:0] a, input logic [7:0] d);
    integer k;
    @(posedge clock);
    {reqValid, reqWrite, reqAddr, reqData} <= {1'b1, w, a, d};
    k = 0;
    do begin @(negedge clock); k++; end while (!reqReady && k < 20);
    @(posedge clock);
    reqValid <= 1'b0;
  endtask
  task rd(input logic [14:0] a, input logic [7:0] e);
    integer k;
    req(1'b0, a, 8'h0);
    k = 0;
    do begin @(negedge clock); k++; end while (!rspValid && k < 8);
    check("rspValid", {7'h0, rspValid}, 8'h1);
    check("rspData", rspData, e);
  endtask
  // Host keeps reqReady low through the wait, then raises it
  task t_powerup;
    repeat (PU) begin
      @(negedge clock);
      check("reqReady", {7'h0, reqReady}, 8'h0);
    end
    @(negedge clock);
    check("reqReady", {7'h0, reqReady}, 8'h1);
  endtask
  // Back-to-back writes at both address ends, overwrite, read back
  task t_rw;
    req(1'b1, 15'h0, 8'ha5);
    req(1'b1, 15'h7fff, 8'h5a);
    req(1'b1, 15'h0, 8'hc3);
    rd(15'h7fff, 8'h5a);
    rd(15'h0, 8'hc3);
  endtask
  // A request offered while busy must be dropped
  task t_refused;
    req(1'b1, 15'h0055, 8'h11);
    @(posedge clock);
    {reqValid, reqWrite, reqAddr, reqData} <= {1'b1, 1'b1, 15'h0055, 8'hee};
    repeat (2) @(posedge clock);
    reqValid <= 1'b0;
    rd(15'h0055, 8'h11);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      err_total++;
      close_out;
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_powerup;
    t_rw;
    t_refused;
    close_out;
  end
endmodule // bytewide_nv_ram_port_tb
